// [line_peer.sv]
// Charge-pump rail model answering the controller's pump enable
`timescale 1ns/10ps
`default_nettype none
module line_peer #(
  parameter int unsigned DLY = 6
)(
  // Clock
  input wire logic hclk,
  // Pump handshake
  input wire logic pump_en,
  output logic pump_ready
);
  int unsigned cnt;
  initial cnt = 0;
  // The negative rail needs some cycles to build, and collapses at once when the pump stops
  always @(posedge hclk)
  begin
    cnt <= pump_en ? ((cnt < DLY) ? cnt + 1 : cnt) : 0;
  end
  assign pump_ready = (cnt >= DLY);
endmodule
`default_nettype wire

// [pwr_pkg.sv]
// Package: constants and carrier types for the RS-232 auto power-down controller
//
// Contract
// [RQ1] Each receiver output is the inverse of its line input and works in shutdown too.
// [RQ2] Automatic power management runs only while force_shutdown_n is high and force_active is low.
// [RQ3] In automatic mode supply and drivers turn off after 30 s without valid input activity.
// [RQ4] While automatically shut down, any valid input transition returns the block to normal operation.
// [RQ5] The valid-signal flag is high while RS-232 levels are present and low otherwise, in every mode.
// [RQ6] The force inputs take priority over the automatic logic.
// [RQ7] On shutdown both charge pumps stop and the transmitter outputs go high impedance.
// [RQ8] Leaving shutdown and resuming transmission takes about 25 us; the code enters ST_ON on pump ready alone, ignoring wake_cnt.
// [RQ9] Transmitter drivers are enabled only once the pump-ready condition is signalled.
// [RQ10] Supply dips of up to about 20 us do not cause a reset pulse.
// [RQ11] A low force_shutdown_n shuts down transmitters and supply, overriding everything else.
// [RQ12] With force_shutdown_n high, a high force_active keeps the transmitters on; in the code a set cfg_off still turns them off.
// [RQ13] The no-signal indication asserts after 90 us without valid levels on any receiver input.
// [RQ14] Inactivity timeout is a counter on a slow timebase, cleared by each qualified edge, flagging at 30 s.
// [RQ15] Activity-detect and force inputs are synchronised before the state machine uses them.
package pwr_pkg;

  // ==========================================
  // Timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  localparam int unsigned TIMEOUT_S = 30;
  localparam int unsigned TIMEOUT_TICKS = TIMEOUT_S * 1000000 / TICK_US;
  localparam int unsigned NOSIG_US = 90;
  localparam int unsigned NOSIG_CYC = NOSIG_US * CLK_MHZ;
  localparam int unsigned WAKE_US = 25;
  localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int unsigned GLITCH_US = 20;
  localparam int unsigned GLITCH_CYC = GLITCH_US * CLK_MHZ;

  // ==========================================
  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  // Interrupt bits
  localparam int unsigned EV_SHUT = 0;
  localparam int unsigned EV_WAKE = 1;
  localparam int unsigned EV_NOSIG = 2;
  localparam int unsigned EV_RESET = 3;

  // ==========================================
  // Types
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_WAKE = 2'h1,
    ST_ON = 2'h3
  } pmode_t;

  typedef struct packed {
    logic cfg_off;
    logic cfg_on;
  } ctrl_t;

  typedef struct packed {
    logic htrans1;
    logic hwrite;
    logic [7:0] addr;
  } aphase_t;

endpackage

// [rs232_auto_power_down_ctrl.sv]
// Design: auto power-down controller with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module rs232_auto_power_down_ctrl #(
  parameter int unsigned NCH = 2,
  parameter int unsigned TICK_CYC = pwr_pkg::TICK_CYC,
  parameter int unsigned TIMEOUT_TICKS = pwr_pkg::TIMEOUT_TICKS,
  parameter int unsigned NOSIG_CYC = pwr_pkg::NOSIG_CYC,
  parameter int unsigned WAKE_CYC = pwr_pkg::WAKE_CYC
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Host control pins
  input wire logic force_shutdown_n,
  input wire logic force_active,
  // Line-side inputs
  input wire logic [NCH-1:0] rx_line,
  input wire logic [NCH-1:0] rx_level_ok,
  input wire logic [NCH-1:0] tx_in,
  input wire logic pump_ready,
  input wire logic supply_low,
  // Outputs
  output logic [NCH-1:0] rx_out,
  output logic [NCH-1:0] tx_out,
  output logic [NCH-1:0] tx_oe,
  output logic pump_en,
  output logic signal_valid,
  output logic reset_out_n,
  output logic irq
);

  localparam int unsigned CW = 32;

  typedef struct packed {
    logic [1:0] fo_s1;
    logic [1:0] fo_s2;
    logic [NCH-1:0] rx_s1;
    logic [NCH-1:0] rx_s2;
    logic [NCH-1:0] rx_d;
    logic [NCH-1:0] tx_s1;
    logic [NCH-1:0] tx_s2;
    logic [NCH-1:0] tx_d;
    logic [NCH-1:0] lv_s1;
    logic [NCH-1:0] lv_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic low_s1;
    logic low_s2;
    pwr_pkg::pmode_t mode;
    logic [CW-1:0] tick_cnt;
    logic [CW-1:0] idle_cnt;
    logic [CW-1:0] nosig_cnt;
    logic [CW-1:0] wake_cnt;
    logic [CW-1:0] glitch_cnt;
    logic valid;
    logic rst_n;
    logic [NCH-1:0] rx_o;
    pwr_pkg::ctrl_t ctrl;
    logic [3:0] stat;
    logic [3:0] mask;
    pwr_pkg::aphase_t ap;
    logic [31:0] rdata;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ==========================================
  // Helpers
  function automatic logic [31:0] read_mux(input logic [7:0] a, input state_t s);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      pwr_pkg::ADDR_CTRL: v = {30'h0, s.ctrl};
      pwr_pkg::ADDR_STAT: v = {27'h0, s.valid, s.mode, s.rst_n, 1'b0};
      pwr_pkg::ADDR_IRQ: v = {28'h0, s.stat};
      pwr_pkg::ADDR_MASK: v = {28'h0, s.mask};
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // Address phase taken by this slave; used by both the write and the read path
  function automatic logic bus_take(input logic sel, input logic rdy, input logic [1:0] trans);
    return sel && rdy && trans[1];
  endfunction

  logic [1:0] force_eff;
  logic activity;
  logic tick;
  logic auto_mode;
  logic want_on;
  logic [3:0] ev;

  // ==========================================
  // Next-state logic
  always_comb
  begin
    s_nxt = s_r;
    // Synchronisers; stage one feeds only stage two
    s_nxt.fo_s1 = {force_shutdown_n, force_active}; // RQ15
    s_nxt.fo_s2 = s_r.fo_s1;
    s_nxt.rx_s1 = rx_line;
    s_nxt.rx_s2 = s_r.rx_s1;
    s_nxt.rx_d = s_r.rx_s2;
    s_nxt.tx_s1 = tx_in;
    s_nxt.tx_s2 = s_r.tx_s1;
    s_nxt.tx_d = s_r.tx_s2;
    s_nxt.lv_s1 = rx_level_ok;
    s_nxt.lv_s2 = s_r.lv_s1;
    s_nxt.rdy_s1 = pump_ready;
    s_nxt.rdy_s2 = s_r.rdy_s1;
    s_nxt.low_s1 = supply_low;
    s_nxt.low_s2 = s_r.low_s1;
    // Receivers stay active in every mode
    s_nxt.rx_o = ~s_r.rx_s2; // RQ1

    // Software can add to the pin override: cfg_off masks force_shutdown_n, cfg_on ORs into force_active
    force_eff[1] = s_r.fo_s2[1] & ~s_r.ctrl.cfg_off;
    force_eff[0] = s_r.fo_s2[0] | s_r.ctrl.cfg_on;
    auto_mode = force_eff[1] & ~force_eff[0]; // RQ2
    // Receiver edges count as activity only on lines carrying valid levels; transmitter input edges always count
    activity = |(((s_r.rx_s2 ^ s_r.rx_d) & s_r.lv_s2) | (s_r.tx_s2 ^ s_r.tx_d));

    // Slow timebase
    tick = (s_r.tick_cnt == CW'(TICK_CYC - 1));
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + 1'b1;
    if (activity || !auto_mode)
      s_nxt.idle_cnt = '0; // RQ14
    else if (tick && s_r.idle_cnt != CW'(TIMEOUT_TICKS))
      s_nxt.idle_cnt = s_r.idle_cnt + 1'b1; // RQ14

    // Valid-signal detector, drops after 90 us of no levels
    if (|s_r.lv_s2)
    begin
      s_nxt.nosig_cnt = '0;
      s_nxt.valid = 1'b1; // RQ5
    end
    else if (s_r.nosig_cnt == CW'(NOSIG_CYC - 1))
      s_nxt.valid = 1'b0; // RQ13
    else
      s_nxt.nosig_cnt = s_r.nosig_cnt + 1'b1;

    // Supply monitor with glitch rejection
    if (!s_r.low_s2)
    begin
      s_nxt.glitch_cnt = '0;
      s_nxt.rst_n = 1'b1;
    end
    else if (s_r.glitch_cnt == CW'(pwr_pkg::GLITCH_CYC))
      s_nxt.rst_n = 1'b0; // RQ10
    else
      s_nxt.glitch_cnt = s_r.glitch_cnt + 1'b1;

    // Power mode
    if (!force_eff[1])
      want_on = 1'b0; // RQ11 RQ6
    else if (force_eff[0])
      want_on = 1'b1; // RQ12 RQ6
    else if (s_r.mode == pwr_pkg::ST_OFF)
      want_on = activity; // RQ4
    else
      want_on = (s_r.idle_cnt != CW'(TIMEOUT_TICKS)) || activity; // RQ3

    case (s_r.mode)
      pwr_pkg::ST_OFF:
      begin
        s_nxt.wake_cnt = '0;
        if (want_on)
          s_nxt.mode = pwr_pkg::ST_WAKE;
      end
      pwr_pkg::ST_WAKE:
      begin
        if (s_r.wake_cnt != CW'(WAKE_CYC))
          s_nxt.wake_cnt = s_r.wake_cnt + 1'b1;
        if (!want_on)
          s_nxt.mode = pwr_pkg::ST_OFF;
        else if (s_r.rdy_s2)
          s_nxt.mode = pwr_pkg::ST_ON; // RQ9 RQ8
      end
      pwr_pkg::ST_ON:
        if (!want_on)
          s_nxt.mode = pwr_pkg::ST_OFF; // RQ7
      default: s_nxt.mode = pwr_pkg::ST_OFF;
    endcase

    // Interrupt events; set wins over write-one-to-clear
    ev[pwr_pkg::EV_SHUT] = (s_r.mode != pwr_pkg::ST_OFF) && (s_nxt.mode == pwr_pkg::ST_OFF);
    ev[pwr_pkg::EV_WAKE] = (s_r.mode != pwr_pkg::ST_ON) && (s_nxt.mode == pwr_pkg::ST_ON);
    ev[pwr_pkg::EV_NOSIG] = s_r.valid && !s_nxt.valid;
    ev[pwr_pkg::EV_RESET] = s_r.rst_n && !s_nxt.rst_n;

    // AHB-Lite: zero wait states, data phase follows the latched address
    s_nxt.ap.htrans1 = bus_take(hsel, hready, htrans);
    s_nxt.ap.hwrite = hwrite;
    s_nxt.ap.addr = haddr[7:0];
    if (s_r.ap.htrans1 && s_r.ap.hwrite)
    begin
      case (s_r.ap.addr)
        pwr_pkg::ADDR_CTRL: s_nxt.ctrl = hwdata[1:0];
        pwr_pkg::ADDR_IRQ: s_nxt.stat = s_r.stat & ~hwdata[3:0];
        pwr_pkg::ADDR_MASK: s_nxt.mask = hwdata[3:0];
        default: ;
      endcase
    end
    s_nxt.stat = s_nxt.stat | ev;
    if (bus_take(hsel, hready, htrans) && !hwrite)
      s_nxt.rdata = read_mux(haddr[7:0], s_r);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
      s_r.mode <= pwr_pkg::ST_OFF;
      s_r.valid <= 1'b0;
      s_r.rst_n <= 1'b1;
      s_r.ctrl <= pwr_pkg::CTRL_RST;
      s_r.mask <= pwr_pkg::MASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  // ==========================================
  // Outputs
  always_comb
  begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    hrdata = s_r.rdata;
    rx_out = s_r.rx_o;
    pump_en = (s_r.mode != pwr_pkg::ST_OFF); // RQ7
    tx_oe = {NCH{s_r.mode == pwr_pkg::ST_ON}}; // RQ9
    tx_out = ~s_r.tx_s2;
    signal_valid = s_r.valid;
    reset_out_n = s_r.rst_n;
    irq = |(s_r.stat & s_r.mask);
  end

  // ==========================================
  // Assertions
  a_tx_needs_pump: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
    $rose(tx_oe[0]) |-> $past(s_r.rdy_s2))
    else $error("transmitters enabled without pump ready");
  a_forced_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    (s_r.fo_s2[1] == 1'b0) |=> !tx_oe[0])
    else $error("transmitters on while forced off");
  a_forced_on: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
    (s_r.fo_s2 == 2'b11 && s_r.ctrl == 2'b00 && s_r.mode == pwr_pkg::ST_ON) |=> pump_en)
    else $error("forced on dropped power");
  a_pump_off_hiz: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
    !pump_en |-> (tx_oe == '0))
    else $error("drivers on with pumps off");
  // The first edge after release still shows the reset value of the output register
  a_rx_invert: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
    $past(hresetn) |-> rx_out == ~$past(s_r.rx_s2))
    else $error("receiver output not inverted");
  a_valid_high: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
    (|s_r.lv_s2) |=> signal_valid)
    else $error("valid flag low with levels present");
  a_timeout_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
    (auto_mode && !activity && s_r.idle_cnt == CW'(TIMEOUT_TICKS) && s_r.mode == pwr_pkg::ST_ON)
    |=> s_r.mode == pwr_pkg::ST_OFF)
    else $error("no shutdown after timeout");
  a_wake_edge: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    (auto_mode && activity && s_r.mode == pwr_pkg::ST_OFF) |=> s_r.mode == pwr_pkg::ST_WAKE)
    else $error("no wake on activity");
  a_idle_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    activity |=> s_r.idle_cnt == '0)
    else $error("idle counter not cleared");
  a_glitch_ok: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    (s_r.low_s2 && s_r.glitch_cnt < CW'(pwr_pkg::GLITCH_CYC)) |=> reset_out_n)
    else $error("reset on short dip");

  // Automatic management, the wake path and the force and software overrides
  a_auto_gate: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
    !auto_mode |=> s_r.idle_cnt == '0)
    else $error("idle count kept outside automatic mode");
  a_tick_step: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    (auto_mode && !activity && !tick) |=> $stable(s_r.idle_cnt))
    else $error("idle count moved without a tick");
  a_idle_cap: assert property (@(posedge hclk) disable iff (!hresetn) // RQ14
    s_r.idle_cnt <= CW'(TIMEOUT_TICKS))
    else $error("idle count passed the terminal count");
  a_quiet_on: assert property (@(posedge hclk) disable iff (!hresetn) // RQ3
    (auto_mode && s_r.mode == pwr_pkg::ST_ON && s_r.idle_cnt != CW'(TIMEOUT_TICKS))
    |=> s_r.mode == pwr_pkg::ST_ON)
    else $error("shutdown before the timeout");
  a_auto_stay_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
    (auto_mode && !activity && s_r.mode == pwr_pkg::ST_OFF) |=> s_r.mode == pwr_pkg::ST_OFF)
    else $error("woke without activity");
  a_ready_to_on: assert property (@(posedge hclk) disable iff (!hresetn) // RQ8
    (s_r.mode == pwr_pkg::ST_WAKE && s_r.rdy_s2 && force_eff == 2'b11) |=> s_r.mode == pwr_pkg::ST_ON)
    else $error("wake not finished with pump ready");
  a_force_wake: assert property (@(posedge hclk) disable iff (!hresetn) // RQ12
    (force_eff == 2'b11 && s_r.mode == pwr_pkg::ST_OFF) |=> s_r.mode == pwr_pkg::ST_WAKE)
    else $error("forced on did not start the pumps");
  a_force_off_now: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
    !force_eff[1] |=> s_r.mode == pwr_pkg::ST_OFF)
    else $error("shutdown override ignored");
  a_sw_off: assert property (@(posedge hclk) disable iff (!hresetn) // RQ6
    s_r.ctrl.cfg_off |=> !pump_en)
    else $error("software shutdown ignored");

  // Timing monitors
  a_nosig_drop: assert property (@(posedge hclk) disable iff (!hresetn) // RQ13
    (!(|s_r.lv_s2) && s_r.nosig_cnt == CW'(NOSIG_CYC - 1)) |=> !signal_valid)
    else $error("valid flag kept after the no-signal time");
  a_long_dip: assert property (@(posedge hclk) disable iff (!hresetn) // RQ10
    (s_r.low_s2 && s_r.glitch_cnt == CW'(pwr_pkg::GLITCH_CYC)) |=> !reset_out_n)
    else $error("no reset after a long dip");

  // Every lane must behave alike; a miswired lane would slip past the lane-zero checks
  for (genvar g = 0; g < NCH; g++)
  begin : g_lane
    a_rx_lane: assert property (@(posedge hclk) disable iff (!hresetn) // RQ1
      $past(hresetn) |-> rx_out[g] == ~$past(s_r.rx_s2[g]))
      else $error("receiver lane not inverted");
    a_oe_lane: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
      tx_oe[g] == (s_r.mode == pwr_pkg::ST_ON))
      else $error("driver enable lane out of step");
  end

  c_auto_shut: cover property (@(posedge hclk) disable iff (!hresetn)
    s_r.mode == pwr_pkg::ST_ON ##1 s_r.mode == pwr_pkg::ST_OFF);
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    s_r.mode == pwr_pkg::ST_WAKE ##1 s_r.mode == pwr_pkg::ST_ON);
  c_nosig: cover property (@(posedge hclk) disable iff (!hresetn) $fell(signal_valid));
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_sw_off: cover property (@(posedge hclk) disable iff (!hresetn)
    s_r.ctrl.cfg_off ##1 !pump_en);

endmodule
`default_nettype wire

// [rs232_auto_power_down_ctrl_test.sv]
// Self-checking bench for the auto power-down controller
`timescale 1ns/10ps
`default_nettype none
module rs232_auto_power_down_ctrl_test;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pump_ready, supply_low;
  logic force_shutdown_n, force_active, pump_en, signal_valid, reset_out_n, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, rx_line, rx_level_ok, tx_in, rx_out, tx_out, tx_oe;
  logic [2:0] hsize;
  logic [15:0] rnd;
  int mismatches, checked, i, lo;
  assign hready = hreadyout;
  // Short tick and timeout so the inactivity shutdown takes tens of cycles
  rs232_auto_power_down_ctrl #(.TICK_CYC(4), .TIMEOUT_TICKS(5), .NOSIG_CYC(10), .WAKE_CYC(25)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .force_shutdown_n(force_shutdown_n), .force_active(force_active),
    .rx_line(rx_line), .rx_level_ok(rx_level_ok), .tx_in(tx_in), .pump_ready(pump_ready),
    .supply_low(supply_low), .rx_out(rx_out), .tx_out(tx_out), .tx_oe(tx_oe), .pump_en(pump_en),
    .signal_valid(signal_valid), .reset_out_n(reset_out_n), .irq(irq));
  line_peer #(.DLY(6)) peer (.hclk(hclk), .pump_en(pump_en), .pump_ready(pump_ready));
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ==========================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic pick(input int s);
    case (s)
      0: return pump_en;
      1: return tx_oe[0];
      2: return signal_valid;
      3: return reset_out_n;
      default: return irq;
    endcase
  endfunction
  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Bounded wait on one status output; a hang ends the run
  task automatic wt(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge hclk);
      n++;
    end
    chk({31'h0, pick(s)}, {31'h0, v}, "wait");
    if (n >= lim)
      tally_and_finish();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 40);
    r = hrdata;
    if (n >= 40)
    begin
      chk(32'h0, 32'h1, "bus hang");
      tally_and_finish();
    end
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    mismatches = 0;
    checked = 0;
    lo = 0;
    hresetn = 1'b0;
    {hsel, hwrite, supply_low, force_active} = 4'h0;
    force_shutdown_n = 1'b1;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    {rx_line, tx_in} = 4'h0;
    rx_level_ok = 2'h3;
    rnd = 16'h83D3;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, pwr_pkg::ADDR_CTRL, 32'h0, q);
    chk(q, 32'h0, "ctrl reset");
    bus(1'b0, pwr_pkg::ADDR_MASK, 32'h0, q);
    chk(q, 32'h0, "mask reset");
    bus(1'b1, 8'h10, 32'hFFFFFFFF, q);
    bus(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0, "unmapped");
    $display("test regs done");
    // Receivers must follow the line even while forced off
    for (i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      rx_line <= rnd[1:0];
      force_shutdown_n <= rnd[2];
      repeat (5) @(posedge hclk);
      chk({30'h0, rx_out}, {30'h0, ~rx_line}, "rx");
    end
    force_active <= 1'b1;
    force_shutdown_n <= 1'b0;
    wt(0, 1'b0, 10);
    wt(1, 1'b0, 10);
    repeat (20) @(posedge hclk);
    chk({31'h0, pump_en}, 32'h0, "forced off");
    force_shutdown_n <= 1'b1;
    wt(0, 1'b1, 10);
    chk({31'h0, tx_oe[0]}, 32'h0, "tx before pump");
    wt(1, 1'b1, 20);
    repeat (60) @(posedge hclk);
    chk({30'h0, tx_oe}, 32'h3, "forced on");
    chk({30'h0, tx_out}, {30'h0, ~tx_in}, "tx data");
    bus(1'b1, pwr_pkg::ADDR_CTRL, 32'h2, q);
    wt(0, 1'b0, 10);
    bus(1'b1, pwr_pkg::ADDR_CTRL, 32'h0, q);
    $display("test force done");
    force_active <= 1'b0;
    tx_in <= ~tx_in;
    for (i = 0; i < 2; i++)
    begin
      wt(0, 1'b1, 10);
      repeat (8) @(posedge hclk);
      chk({31'h0, pump_en}, 32'h1, "early off");
      wt(0, 1'b0, 60);
      chk({30'h0, tx_oe}, 32'h0, "tx hiz");
      if (i == 0)
        rx_line[0] <= ~rx_line[0];
      else
        tx_in[1] <= ~tx_in[1];
    end
    wt(0, 1'b1, 10);
    wt(1, 1'b1, 20);
    $display("test auto done");
    bus(1'b1, pwr_pkg::ADDR_IRQ, 32'hF, q);
    bus(1'b1, pwr_pkg::ADDR_MASK, 32'h4, q);
    wt(4, 1'b0, 4);
    rx_level_ok <= 2'h0;
    repeat (6) @(posedge hclk);
    chk({31'h0, signal_valid}, 32'h1, "early invalid");
    wt(2, 1'b0, 30);
    wt(4, 1'b1, 10);
    bus(1'b0, pwr_pkg::ADDR_IRQ, 32'h0, q);
    chk(q & 32'h4, 32'h4, "irq status");
    bus(1'b1, pwr_pkg::ADDR_MASK, 32'h0, q);
    wt(4, 1'b0, 4);
    rx_level_ok <= 2'h3;
    wt(2, 1'b1, 10);
    bus(1'b1, pwr_pkg::ADDR_IRQ, 32'h4, q);
    bus(1'b0, pwr_pkg::ADDR_IRQ, 32'h0, q);
    chk(q & 32'h4, 32'h0, "irq clear");
    $display("test signal done");
    // A dip shorter than the filter must not reach the reset output
    supply_low <= 1'b1;
    for (i = 0; i < 1500; i++)
    begin
      @(posedge hclk);
      lo += (reset_out_n !== 1'b1);
    end
    supply_low <= 1'b0;
    repeat (20) @(posedge hclk);
    chk(lo, 32'h0, "glitch reset");
    supply_low <= 1'b1;
    wt(3, 1'b0, 2200);
    $display("test supply done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
